// ===== bench/remote_modem.sv
// remote modem model: echoes the block's line back one cycle late and
// drives the active-low modem status lines that the bench asks for
`timescale 1ns/1ps

module remote_modem (
  input wire logic clk_i,
  input wire logic tx_i,
  input wire logic [3:0] lines_i,
  output logic rx_o,
  output logic [3:0] lines_n_o
);
  // the echo keeps the far line at the idle level of either mode
  initial rx_o = 1'b1;
  initial lines_n_o = 4'hF;
  always @(posedge clk_i) begin
    rx_o <= tx_i;
    lines_n_o <= ~lines_i;
  end
endmodule

// ===== bench/uart_format_modem_control_tb_top.sv
// bench top: axi4-lite master, remote modem and line timing checks
// assumes the map header offsets and a divisor left at its reset value
`timescale 1ns/1ps
`include "uart_fmt_map.svh"

module uart_format_modem_control_tb_top;
  localparam logic [7:0] MC = `MODEM_CONTROL_OFF;
  localparam logic [7:0] ST = `INT_STATUS_OFF;
  localparam logic [7:0] IE = `INT_ENABLE_OFF;
  logic clk = 1'b0, rst_n_i = 1'b0, aw = 1'b0, w = 1'b0, br = 1'b0;
  logic ar = 1'b0, rr = 1'b0, awr, wr_r, bv, arr, rv, tx, rx, tx_q;
  logic rts_n, dtr_n, irq, oe;
  logic [7:0] awa = 8'h0, ara = 8'h0;
  logic [31:0] wd = 32'h0, rd_d, seed = 32'h54;
  logic [1:0] rsp, bre;
  logic [3:0] ext = 4'h0, md;
  logic [33:0] q[$];
  int n_errors = 0, check_count = 0, lo_n, hi_n, lo_last, hi_last;

  uart_format_modem_control i_uart_format_modem_control (
    .mclk_i(clk), .rst_n_i(rst_n_i), .s_axi_awaddr_i(awa),
    .s_axi_awprot_i(3'h0), .s_axi_awvalid_i(aw), .s_axi_awready_o(awr),
    .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(w),
    .s_axi_wready_o(wr_r), .s_axi_bresp_o(bre), .s_axi_bvalid_o(bv),
    .s_axi_bready_i(br), .s_axi_araddr_i(ara), .s_axi_arprot_i(3'h0),
    .s_axi_arvalid_i(ar), .s_axi_arready_o(arr), .s_axi_rdata_o(rd_d),
    .s_axi_rresp_o(rsp), .s_axi_rvalid_o(rv), .s_axi_rready_i(rr),
    .tx_o(tx), .rx_i(rx), .cts_n_i(md[3]), .dsr_n_i(md[2]),
    .ri_n_i(md[1]), .dcd_n_i(md[0]), .rts_n_o(rts_n), .dtr_n_o(dtr_n),
    .irq_o(irq), .irq_oe_o(oe));
  remote_modem i_remote_modem (.clk_i(clk), .tx_i(tx), .lines_i(ext),
    .rx_o(rx), .lines_n_o(md));

  task automatic chk(input string nm, input logic [33:0] s, e);
    check_count++;
    if (s !== e) begin
      n_errors++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  // extra edges after the response let registered pins settle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awa <= a; wd <= d; aw <= 1'b1; w <= 1'b1; br <= 1'b1;
    do begin
      @(posedge clk);
      if (awr) aw <= 1'b0;
      if (wr_r) w <= 1'b0;
    end while (!bv);
    chk("bresp", {32'h0, bre},
        {32'h0, (a == 8'h1C) ? `RESP_SLVERR : `RESP_OKAY});
    br <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    @(posedge clk);
    q.push_back(e);
    ara <= a; ar <= 1'b1; rr <= 1'b1;
    do begin
      @(posedge clk);
      if (arr) ar <= 1'b0;
    end while (!rv);
    rr <= 1'b0;
  endtask
  // stop length is seen as the gap before a retried write starts a frame
  task automatic frame(input logic [7:0] lc, mc, input int le, st);
    int p;
    p = mc[7] ? 64 : 16;
    seed = xs(seed);
    wr(MC, {24'h0, mc});
    wr(`LINE_CONTROL_OFF, {24'h0, lc});
    wr(`TX_DATA_OFF, 32'h0);
    wait (tx === 1'b0);
    wait (tx === 1'b1);
    repeat (2) @(posedge clk);
    // the start bit begins off the baud tick grid: up to one tick short
    chk("low run", lo_last > le - p && lo_last <= le, 1'b1);
    while (tx !== 1'b0) wr(`TX_DATA_OFF, seed);
    repeat (2) @(posedge clk);
    chk("stop", hi_last >= st && hi_last < st + 100, 1'b1);
    repeat (le + st + 100) @(posedge clk);
    rd(`RX_DATA_OFF,
       {26'h0, seed[7:0] & (8'hFF >> (2'h3 - lc[1:0]))});
  endtask

  initial forever #2.5 clk = ~clk;
  always @(posedge clk) begin
    tx_q <= tx;
    lo_n <= tx ? 0 : lo_n + 1;
    hi_n <= tx ? hi_n + 1 : 0;
    if (tx && !tx_q) lo_last <= lo_n;
    if (!tx && tx_q) hi_last <= hi_n;
    if (rv && rr && q.size() > 0) chk("rd", {rsp, rd_d}, q.pop_front());
  end
  initial begin
    #400000;
    n_errors++;
    finish_test();
  end
  initial begin
    logic [3:0] m;
    seed = xs(seed);
    m = seed[3:0] | 4'h1;
    repeat (4) @(posedge clk);
    rst_n_i <= 1'b1;
    rd(MC, 34'h0);
    rd(8'h1C, {2'h2, 32'h0});
    wr(8'h1C, 32'h0);
    rd(`BAUD_DIV_OFF, 34'h1);
    chk("idle", {tx, oe}, 2'h2);
    wr(MC, {28'h1, m});
    ext <= 4'hF;
    chk("lb", {tx, rts_n, dtr_n}, 3'h7);
    rd(ST, {26'h0, m[1], m[0], m[2], m[3], 4'h4});
    seed = xs(seed);
    wr(`TX_DATA_OFF, seed);
    repeat (2000) @(posedge clk);
    rd(ST, {26'h0, m[1], m[0], m[2], m[3], 4'h7});
    rd(`RX_DATA_OFF, {29'h0, seed[4:0]});
    wr(IE, 32'h4);
    wr(MC, {28'h3, m});
    chk("os", {irq, oe}, 2'h3);
    wr(ST, 32'h4);
    chk("clr", oe, 1'b0);
    wr(IE, 32'h0);
    wr(MC, {28'h1, 1'b1, m[2], ~m[1], m[0]});
    chk("mask", {irq, oe}, 2'h1);
    wr(IE, 32'h4);
    chk("act", {irq, oe}, 2'h3);
    wr(MC, 32'h0);
    chk("rel", {irq, oe}, 2'h2);
    wr(IE, 32'h0);
    for (int b = 0; b < 4; b++)
      frame({6'h1, b[1:0]}, 8'h0, (6 + b) * 256, b ? 512 : 384);
    frame(8'h0, 8'h80, 6144, 1024);
    wr(MC, 32'h40);
    chk("ir", tx, 1'b0);
    seed = xs(seed);
    wr(`TX_DATA_OFF, seed);
    repeat (2000) @(posedge clk);
    rd(`RX_DATA_OFF, {29'h0, seed[4:0]});
    finish_test();
  end
endmodule

// ===== include/uart_fmt_map.svh
// register map, field positions and timing counts of the uart format block
// assumes byte addresses on an 8-bit slice of the axi4-lite address
`ifndef UART_FMT_MAP_SVH
`define UART_FMT_MAP_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define LINE_CONTROL_OFF 8'h00
`define MODEM_CONTROL_OFF 8'h04
`define INT_ENABLE_OFF 8'h08
`define INT_STATUS_OFF 8'h0C
`define TX_DATA_OFF 8'h10
`define RX_DATA_OFF 8'h14
`define BAUD_DIV_OFF 8'h18

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define LC_STOP 2
`define MC_CLK_SEL 7
`define MC_IR_EN 6
`define MC_INT_TYPE 5
`define MC_LOOP 4
`define MC_AUX_TWO 3
`define MC_AUX_ONE 2
`define MC_RTS 1
`define MC_DTR 0
`define ST_RX_READY 0
`define ST_TX_DONE 1
`define ST_MODEM 2

// ----------------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------------
`define LC_RESET 8'h00
`define MC_RESET 8'h00
`define DIV_RESET 16'h0001
`define PRE_LAST 4'hF
`define QUAD_LAST 2'h3
`define BIT_LAST 6'h0F
`define BIT_MID 6'h07
`define IR_PULSE_TICKS 4'h3
`define IR_HOLD_TICKS 5'h10
`define STOP_ONE 6'h10
`define STOP_ONE_HALF 6'h18
`define STOP_TWO 6'h20
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ===== include/uart_fmt_pkg.sv
// types shared by the uart format and modem control block
// assumes the map header supplies all numeric constants
package uart_fmt_pkg;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_START = 2'b01,
    TX_DATA = 2'b10,
    TX_STOP = 2'b11
  } tx_state_e;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b10,
    RX_STOP = 2'b11
  } rx_state_e;

  // modem status lines, active high inside the block
  typedef struct packed {
    logic cts;
    logic dsr;
    logic ri;
    logic dcd;
  } modem_s;

endpackage

// ===== src/uart_format_modem_control.sv
// uart character format, baud prescale, infrared path, interrupt drive
// and loop-back, with an axi4-lite register slave.
// assumes all pins synchronous to mclk_i; modem pins are active low.
//
// Functional notes
// - stop select: one, or 1.5/2 stop bits
// - word-length field selects 5 to 8 bits
// - clock select 0: divide by 16 only
// - clock select 1: further divide by four
// - infrared off: plain serial pins used
// - infrared idle transmit output held low
// - type 0: interrupt driven active or inactive while aux two set, else released
// - type 1: open-source interrupt for wired-or
// - loop-back disconnects tx and modem inputs
// - loop-back ties data and control internally
// - loop-back keeps rx and tx interrupts
// - loop-back modem status from control bits
// - interrupt enable gates sources in loop-back
// - reset clears clock, infrared, type, loop
// - aux one to ring, aux two to carrier
`timescale 1ns/1ps
`include "uart_fmt_map.svh"

module uart_format_modem_control (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic [2:0] s_axi_awprot_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic [2:0] s_axi_arprot_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic tx_o,
  input wire logic rx_i,
  input wire logic cts_n_i,
  input wire logic dsr_n_i,
  input wire logic ri_n_i,
  input wire logic dcd_n_i,
  output logic rts_n_o,
  output logic dtr_n_o,
  output logic irq_o,
  output logic irq_oe_o
);

  // ----------------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------------
  function automatic logic [3:0] word_bits(input logic [1:0] wl);
    word_bits = 4'h5 + {2'h0, wl};
  endfunction

  function automatic logic [5:0] stop_ticks(input logic sel,
                                            input logic [1:0] wl);
    if (!sel) begin
      stop_ticks = `STOP_ONE;
    end else if (wl == 2'h0) begin
      stop_ticks = `STOP_ONE_HALF;
    end else begin
      stop_ticks = `STOP_TWO;
    end
  endfunction

  function automatic logic is_addr(input logic [7:0] a,
                                   input logic [7:0] off);
    is_addr = (a == off);
  endfunction

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r, rdata_nxt;
  logic [7:0] waddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic wr_fire, wr_hit;
  logic [7:0] line_control_r, modem_control_r, rx_data_r;
  logic [2:0] int_enable_r, status_r, status_set, status_clr;
  logic [15:0] baud_div_r, div_eff;
  logic [3:0] pre_cnt_r;
  logic [1:0] quad_cnt_r;
  logic [15:0] brg_cnt_r;
  logic pre_tick, baud_tick;
  uart_fmt_pkg::tx_state_e tx_state_r;
  uart_fmt_pkg::rx_state_e rx_state_r;
  logic [5:0] tx_cnt_r, tx_stop_lim_r;
  logic [2:0] tx_idx_r;
  logic [3:0] tx_nbits_r;
  logic [7:0] tx_shift_r;
  logic tx_go, tx_line, ir_pulse, tx_done;
  logic [5:0] rx_cnt_r;
  logic [2:0] rx_idx_r;
  logic [3:0] rx_nbits_r;
  logic [7:0] rx_shift_r;
  logic [4:0] ir_hold_r;
  logic ir_dec, rx_src, rx_done;
  uart_fmt_pkg::modem_s modem_now, modem_prev_r;
  logic loop_on, ir_on, pending;

  assign loop_on = modem_control_r[`MC_LOOP];
  assign ir_on = modem_control_r[`MC_IR_EN];

  // ----------------------------------------------------------------------
  // axi4-lite write channel: address and data taken in either order
  // ----------------------------------------------------------------------
  assign wr_fire = !awready_r && !wready_r && !bvalid_r;

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      bvalid_r <= 1'b0;
      bresp_r <= `RESP_OKAY;
      waddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end else begin
      if (awready_r && s_axi_awvalid_i) begin
        awready_r <= 1'b0;
        waddr_r <= s_axi_awaddr_i;
      end
      if (wready_r && s_axi_wvalid_i) begin
        wready_r <= 1'b0;
        wdata_r <= s_axi_wdata_i;
        wstrb_r <= s_axi_wstrb_i;
      end
      if (wr_fire) begin
        bvalid_r <= 1'b1;
        bresp_r <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (bvalid_r && s_axi_bready_i) begin
        bvalid_r <= 1'b0;
        awready_r <= 1'b1;
        wready_r <= 1'b1;
      end
    end
  end

  assign wr_hit = is_addr(waddr_r, `LINE_CONTROL_OFF) ||
                  is_addr(waddr_r, `MODEM_CONTROL_OFF) ||
                  is_addr(waddr_r, `INT_ENABLE_OFF) ||
                  is_addr(waddr_r, `INT_STATUS_OFF) ||
                  is_addr(waddr_r, `TX_DATA_OFF) ||
                  is_addr(waddr_r, `RX_DATA_OFF) ||
                  is_addr(waddr_r, `BAUD_DIV_OFF);

  // ----------------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------------
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    unique case (s_axi_araddr_i)
      `LINE_CONTROL_OFF: rdata_nxt[7:0] = line_control_r;
      `MODEM_CONTROL_OFF: rdata_nxt[7:0] = modem_control_r;
      `INT_ENABLE_OFF: rdata_nxt[2:0] = int_enable_r;
      `INT_STATUS_OFF: rdata_nxt[7:0] = {modem_now, 1'b0, status_r};
      `RX_DATA_OFF: rdata_nxt[7:0] = rx_data_r;
      `BAUD_DIV_OFF: rdata_nxt[15:0] = baud_div_r;
      default: rdata_nxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= `RESP_OKAY;
    end else if (arready_r && s_axi_arvalid_i) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rdata_r <= rdata_nxt;
      rresp_r <= (is_addr(s_axi_araddr_i, `TX_DATA_OFF) ||
                  rdata_nxt != 32'h0000_0000 ||
                  is_addr(s_axi_araddr_i, `LINE_CONTROL_OFF) ||
                  is_addr(s_axi_araddr_i, `MODEM_CONTROL_OFF) ||
                  is_addr(s_axi_araddr_i, `INT_ENABLE_OFF) ||
                  is_addr(s_axi_araddr_i, `INT_STATUS_OFF) ||
                  is_addr(s_axi_araddr_i, `RX_DATA_OFF) ||
                  is_addr(s_axi_araddr_i, `BAUD_DIV_OFF)) ?
                 `RESP_OKAY : `RESP_SLVERR;
    end else if (rvalid_r && s_axi_rready_i) begin
      rvalid_r <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      line_control_r <= `LC_RESET;
      modem_control_r <= `MC_RESET;
      int_enable_r <= 3'h0;
      baud_div_r <= `DIV_RESET;
    end else if (wr_fire) begin
      if (is_addr(waddr_r, `LINE_CONTROL_OFF) && wstrb_r[0]) begin
        line_control_r <= wdata_r[7:0];
      end
      if (is_addr(waddr_r, `MODEM_CONTROL_OFF) && wstrb_r[0]) begin
        modem_control_r <= wdata_r[7:0];
      end
      if (is_addr(waddr_r, `INT_ENABLE_OFF) && wstrb_r[0]) begin
        int_enable_r <= wdata_r[2:0];
      end
      if (is_addr(waddr_r, `BAUD_DIV_OFF)) begin
        if (wstrb_r[0]) begin
          baud_div_r[7:0] <= wdata_r[7:0];
        end
        if (wstrb_r[1]) begin
          baud_div_r[15:8] <= wdata_r[15:8];
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // prescaler and baud generator
  // ----------------------------------------------------------------------
  // a zero divisor would wrap the compare to a divide by 65536, so it behaves as one
  assign div_eff = (baud_div_r == 16'h0000) ? 16'h0001 : baud_div_r;
  assign pre_tick = (pre_cnt_r == `PRE_LAST) &&
                    (!modem_control_r[`MC_CLK_SEL] ||
                     quad_cnt_r == `QUAD_LAST);
  assign baud_tick = pre_tick && (brg_cnt_r >= div_eff - 16'h0001);

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      pre_cnt_r <= 4'h0;
      quad_cnt_r <= 2'h0;
      brg_cnt_r <= 16'h0000;
    end else begin
      pre_cnt_r <= pre_cnt_r + 4'h1;
      if (pre_cnt_r == `PRE_LAST) begin
        quad_cnt_r <= quad_cnt_r + 2'h1;
      end
      if (pre_tick) begin
        brg_cnt_r <= baud_tick ? 16'h0000 : brg_cnt_r + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------------
  // transmitter; format latched at start so a mid-frame write is harmless
  // ----------------------------------------------------------------------
  assign tx_go = wr_fire && is_addr(waddr_r, `TX_DATA_OFF) && wstrb_r[0] &&
                 (tx_state_r == uart_fmt_pkg::TX_IDLE);
  assign tx_line = (tx_state_r == uart_fmt_pkg::TX_START) ? 1'b0 :
                   (tx_state_r == uart_fmt_pkg::TX_DATA) ? tx_shift_r[0] :
                   1'b1;
  assign tx_done = baud_tick && (tx_state_r == uart_fmt_pkg::TX_STOP) &&
                   (tx_cnt_r == tx_stop_lim_r - 6'h01);

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      tx_state_r <= uart_fmt_pkg::TX_IDLE;
      tx_cnt_r <= 6'h00;
      tx_idx_r <= 3'h0;
      tx_shift_r <= 8'h00;
      tx_nbits_r <= 4'h5;
      tx_stop_lim_r <= `STOP_ONE;
    end else begin
      unique case (tx_state_r)
        uart_fmt_pkg::TX_IDLE: begin
          if (tx_go) begin
            tx_state_r <= uart_fmt_pkg::TX_START;
            tx_shift_r <= wdata_r[7:0];
            tx_nbits_r <= word_bits(line_control_r[1:0]);
            tx_stop_lim_r <= stop_ticks(line_control_r[`LC_STOP],
                                        line_control_r[1:0]);
            tx_cnt_r <= 6'h00;
            tx_idx_r <= 3'h0;
          end
        end
        uart_fmt_pkg::TX_START: begin
          if (baud_tick) begin
            tx_cnt_r <= (tx_cnt_r == `BIT_LAST) ? 6'h00 : tx_cnt_r + 6'h01;
            if (tx_cnt_r == `BIT_LAST) begin
              tx_state_r <= uart_fmt_pkg::TX_DATA;
            end
          end
        end
        uart_fmt_pkg::TX_DATA: begin
          if (baud_tick) begin
            tx_cnt_r <= (tx_cnt_r == `BIT_LAST) ? 6'h00 : tx_cnt_r + 6'h01;
            if (tx_cnt_r == `BIT_LAST) begin
              tx_shift_r <= {1'b1, tx_shift_r[7:1]};
              tx_idx_r <= tx_idx_r + 3'h1;
              if ({1'b0, tx_idx_r} == tx_nbits_r - 4'h1) begin
                tx_state_r <= uart_fmt_pkg::TX_STOP;
              end
            end
          end
        end
        uart_fmt_pkg::TX_STOP: begin
          if (baud_tick) begin
            tx_cnt_r <= tx_cnt_r + 6'h01;
            if (tx_done) begin
              tx_state_r <= uart_fmt_pkg::TX_IDLE;
              tx_cnt_r <= 6'h00;
            end
          end
        end
      endcase
    end
  end

  // encoder pulses high for the first 3/16 of each zero bit; idle is low
  assign ir_pulse = !tx_line && (tx_cnt_r[3:0] < `IR_PULSE_TICKS);

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      tx_o <= 1'b1;
    end else if (loop_on) begin
      tx_o <= !ir_on;
    end else begin
      tx_o <= ir_on ? ir_pulse : tx_line;
    end
  end

  // ----------------------------------------------------------------------
  // receiver source selection and infrared decoder
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      ir_hold_r <= 5'h00;
    end else if (rx_i && ir_on) begin
      // loading outside infrared mode would fake a start bit on entry
      ir_hold_r <= `IR_HOLD_TICKS;
    end else if (baud_tick && ir_hold_r != 5'h00) begin
      ir_hold_r <= ir_hold_r - 5'h01;
    end
  end

  assign ir_dec = (ir_hold_r == 5'h00);
  assign rx_src = loop_on ? tx_line : (ir_on ? ir_dec : rx_i);

  // ----------------------------------------------------------------------
  // receiver
  // ----------------------------------------------------------------------
  assign rx_done = baud_tick && (rx_state_r == uart_fmt_pkg::RX_STOP) &&
                   (rx_cnt_r == `BIT_LAST);

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      rx_state_r <= uart_fmt_pkg::RX_IDLE;
      rx_cnt_r <= 6'h00;
      rx_idx_r <= 3'h0;
      rx_shift_r <= 8'h00;
      rx_nbits_r <= 4'h5;
      rx_data_r <= 8'h00;
    end else begin
      unique case (rx_state_r)
        uart_fmt_pkg::RX_IDLE: begin
          if (!rx_src) begin
            rx_state_r <= uart_fmt_pkg::RX_START;
            rx_cnt_r <= 6'h00;
            rx_idx_r <= 3'h0;
            rx_nbits_r <= word_bits(line_control_r[1:0]);
          end
        end
        uart_fmt_pkg::RX_START: begin
          if (baud_tick) begin
            rx_cnt_r <= rx_cnt_r + 6'h01;
            if (rx_cnt_r == `BIT_MID) begin
              // a start bit gone high by mid-bit was noise
              rx_state_r <= rx_src ? uart_fmt_pkg::RX_IDLE :
                                     uart_fmt_pkg::RX_DATA;
              rx_cnt_r <= 6'h00;
            end
          end
        end
        uart_fmt_pkg::RX_DATA: begin
          if (baud_tick) begin
            rx_cnt_r <= (rx_cnt_r == `BIT_LAST) ? 6'h00 : rx_cnt_r + 6'h01;
            if (rx_cnt_r == `BIT_LAST) begin
              rx_shift_r <= {rx_src, rx_shift_r[7:1]};
              rx_idx_r <= rx_idx_r + 3'h1;
              if ({1'b0, rx_idx_r} == rx_nbits_r - 4'h1) begin
                rx_state_r <= uart_fmt_pkg::RX_STOP;
              end
            end
          end
        end
        uart_fmt_pkg::RX_STOP: begin
          if (baud_tick) begin
            rx_cnt_r <= rx_cnt_r + 6'h01;
            if (rx_done) begin
              rx_state_r <= uart_fmt_pkg::RX_IDLE;
              rx_data_r <= rx_shift_r >> (4'h8 - rx_nbits_r);
              rx_cnt_r <= 6'h00;
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // modem lines, loop-back routing and modem outputs
  // ----------------------------------------------------------------------
  always_comb begin
    if (loop_on) begin
      modem_now.cts = modem_control_r[`MC_RTS];
      modem_now.dsr = modem_control_r[`MC_DTR];
      modem_now.ri = modem_control_r[`MC_AUX_ONE];
      modem_now.dcd = modem_control_r[`MC_AUX_TWO];
    end else begin
      modem_now.cts = !cts_n_i;
      modem_now.dsr = !dsr_n_i;
      modem_now.ri = !ri_n_i;
      modem_now.dcd = !dcd_n_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      modem_prev_r <= '0;
      rts_n_o <= 1'b1;
      dtr_n_o <= 1'b1;
    end else begin
      modem_prev_r <= modem_now;
      // loop-back keeps the far end from seeing diagnostic handshakes
      rts_n_o <= loop_on || !modem_control_r[`MC_RTS];
      dtr_n_o <= loop_on || !modem_control_r[`MC_DTR];
    end
  end

  // ----------------------------------------------------------------------
  // interrupt status, mask and output drive
  // ----------------------------------------------------------------------
  assign status_set = {modem_now != modem_prev_r, tx_done, rx_done};
  assign status_clr = (wr_fire && is_addr(waddr_r, `INT_STATUS_OFF) &&
                       wstrb_r[0]) ? wdata_r[2:0] : 3'h0;
  assign pending = |(status_r & int_enable_r);

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      status_r <= 3'h0;
    end else begin
      // a new event in the clearing cycle survives the clear
      status_r <= (status_r & ~status_clr) | status_set;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      irq_o <= 1'b0;
      irq_oe_o <= 1'b0;
    end else if (modem_control_r[`MC_INT_TYPE]) begin
      irq_o <= 1'b1;
      irq_oe_o <= pending;
    end else begin
      irq_o <= pending;
      irq_oe_o <= modem_control_r[`MC_AUX_TWO];
    end
  end

  assign s_axi_awready_o = awready_r;
  assign s_axi_wready_o = wready_r;
  assign s_axi_bvalid_o = bvalid_r;
  assign s_axi_bresp_o = bresp_r;
  assign s_axi_arready_o = arready_r;
  assign s_axi_rvalid_o = rvalid_r;
  assign s_axi_rdata_o = rdata_r;
  assign s_axi_rresp_o = rresp_r;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  stop_length_a: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i)
    tx_go |=> tx_stop_lim_r == (!$past(line_control_r[`LC_STOP]) ?
      `STOP_ONE : ($past(line_control_r[1:0]) == 2'h0) ?
      `STOP_ONE_HALF : `STOP_TWO))
    else $error("stop length wrong for format");
  word_bits_a: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i)
    (tx_state_r == uart_fmt_pkg::TX_DATA) |-> {1'b0, tx_idx_r} < tx_nbits_r)
    else $error("transmit ran past word length");
  prescale_div16_a: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i)
    (pre_tick && !modem_control_r[`MC_CLK_SEL]) |->
      ##16 (pre_tick || modem_control_r[`MC_CLK_SEL]))
    else $error("undivided prescale tick missing");
  prescale_div64_a: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i)
    (pre_tick && modem_control_r[`MC_CLK_SEL]) |->
      ##16 (!pre_tick || !modem_control_r[`MC_CLK_SEL])
      ##48 (pre_tick || !modem_control_r[`MC_CLK_SEL]))
    else $error("divided prescale tick spacing wrong");
  ir_idle_low_a: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i)
    (ir_on && !loop_on && tx_state_r == uart_fmt_pkg::TX_IDLE) |=> !tx_o)
    else $error("infrared idle not low");
  loop_tx_idle_a: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i)
    (loop_on && !ir_on) [*2] |-> tx_o)
    else $error("loop-back leaked onto tx pin");
  loop_route_a: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i)
    loop_on |-> rx_src == tx_line &&
      modem_now.ri == modem_control_r[`MC_AUX_ONE] &&
      modem_now.dcd == modem_control_r[`MC_AUX_TWO])
    else $error("loop-back routing wrong");
  irq_open_src_a: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i)
    (modem_control_r[`MC_INT_TYPE] && !pending) |=> !irq_oe_o)
    else $error("open-source irq driven while idle");
  irq_active_a: assert property (@(posedge mclk_i)
    disable iff (!rst_n_i)
    (!modem_control_r[`MC_INT_TYPE] && pending &&
     modem_control_r[`MC_AUX_TWO]) |=> irq_o && irq_oe_o)
    else $error("active irq not asserted");
  reset_clear_a: assert property (@(posedge mclk_i)
    disable iff (1'b0)
    !rst_n_i |=> modem_control_r[7:4] == 4'h0)
    else $error("control bits not cleared by reset");

endmodule
